//--- rtl/crc_ctl_pkg.sv
package crc_ctl_pkg;

  // register map (byte addresses)
  localparam logic [3:0] ctl_addr     = 4'h0;
  localparam logic [3:0] poly_addr    = 4'h4;
  localparam logic [3:0] result_addr  = 4'h8;
  localparam logic [3:0] seed_addr    = 4'hc;

  // control field positions
  localparam int byte_order_hi   = 29;
  localparam int byte_order_lo   = 28;
  localparam int write_reorder_b = 27;
  localparam int bit_order_b     = 24;
  localparam int poly_len_hi     = 12;
  localparam int poly_len_lo     = 8;
  localparam int enable_b        = 7;
  localparam int append_b        = 6;
  localparam int mode_b          = 5;
  localparam int chan_hi         = 2;
  localparam int chan_lo         = 0;

  // writable bits of the control word
  localparam logic [31:0] ctl_wmask  = 32'h3900_1fe7;
  localparam logic [31:0] ctl_reset  = 32'h0000_0000;
  localparam logic [31:0] zero_word  = 32'h0000_0000;

  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  typedef enum logic [1:0] {
    order_none  = 2'h0,
    order_word  = 2'h1,
    order_half  = 2'h2,
    order_bytes = 2'h3
  } byte_order_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  chan;
    logic [31:0] data;
  } beat_t;

endpackage

//--- rtl/byte_reorder.sv
`timescale 1ns/100ps
`default_nettype none
module byte_reorder
  import crc_ctl_pkg::*;
(
  // control
  input  wire logic [1:0]  order,
  // data
  input  wire logic [31:0] din,
  output logic [31:0]      dout
);
  always_comb begin
    case (order)
      order_none:  dout = din;                                             // see RQ1
      order_word:  dout = {din[7:0], din[15:8], din[23:16], din[31:24]};   // see RQ1
      order_half:  dout = {din[15:0], din[31:16]};                         // see RQ2
      order_bytes: dout = {din[23:16], din[31:24], din[7:0], din[15:8]};   // see RQ2
      default:     dout = din;
    endcase
  end
endmodule
`default_nettype wire

//--- rtl/crc_step.sv
`timescale 1ns/100ps
`default_nettype none
module crc_step
  import crc_ctl_pkg::*;
(
  // configuration
  input  wire logic        ip_mode,
  input  wire logic        reflect,
  input  wire logic [4:0]  poly_len_m1,
  input  wire logic [31:0] poly,
  // data
  input  wire logic [31:0] acc,
  input  wire logic [31:0] din,
  output logic [31:0]      acc_out
);
  logic [31:0] lfsr;
  logic [31:0] top_mask;
  logic [31:0] dbits;
  logic [16:0] sum1;
  logic [16:0] sum2;
  logic [15:0] s16;
  logic        fb;

  always_comb begin
    lfsr     = acc;
    fb       = 1'b0;
    top_mask = 32'h0000_0001 << poly_len_m1;
    dbits    = din;
    if (reflect) begin
      for (int i = 0; i < 32; i++) begin
        dbits[i] = din[31 - i];
      end
    end
    for (int i = 31; i >= 0; i--) begin
      // msb of the programmed length is the feedback tap
      fb   = ((lfsr & top_mask) != zero_word) ^ dbits[i];
      lfsr = (lfsr << 1) & ((top_mask << 1) - 32'h0000_0001);
      if (fb) begin
        lfsr = lfsr ^ (poly & ((top_mask << 1) - 32'h0000_0001));
      end
    end
    // ones-complement sum of the two half-words into the low 16 bits
    sum1 = {1'b0, acc[15:0]} + {1'b0, dbits[31:16]};
    s16  = sum1[15:0] + {15'h0, sum1[16]};
    sum2 = {1'b0, s16} + {1'b0, dbits[15:0]};
    s16  = sum2[15:0] + {15'h0, sum2[16]};
    if (ip_mode) begin
      acc_out = {16'h0000, s16};                                 // see RQ6
    end else begin
      acc_out = lfsr;                                            // see RQ10
    end
  end
endmodule
`default_nettype wire

//--- rtl/dma_crc_control.sv
// Functional notes
// RQ1: byte order 00 keeps, 01 reverses word
// RQ2: 10 swaps half-words, 11 swaps within halves
// RQ3: byte order bits 29:28 feed checksum
// RQ4: write-reorder bit 27 reorders destination data
// RQ5: write-reorder blocks append-result bit
// RQ6: mode bit: 1 IP checksum, 0 LFSR
// RQ7: IP mode bit order 1 reflects
// RQ8: LFSR mode bit order 1 reflects
// RQ9: bit order lives at bit 24
// RQ10: length field 12:8 is length minus one
// RQ11: enable bit 7 routes channel through unit
// RQ12: unimplemented bits ignore writes, read zero
// RQ13: channel field picks the routed channel
// RQ14: all fields reset to zero
`timescale 1ns/100ps
`default_nettype none
module dma_crc_control
  import crc_ctl_pkg::*;
#(
  parameter int channels = 8
)(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // axi4-lite write
  input  wire logic [3:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  // axi4-lite read
  input  wire logic [3:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // dma data path
  input  wire crc_ctl_pkg::beat_t src_beat,
  output crc_ctl_pkg::beat_t dst_beat,
  output logic             append_req
);
  import crc_ctl_pkg::*;

  // the channel field is three bits wide, so more than eight cannot be routed
  if (channels < 1 || channels > 8) begin : g_bad_channels
    $error("channels must be 1..8");
  end

  logic [31:0] ctl_ff, nxt_ctl;
  logic [31:0] poly_ff, nxt_poly;
  logic [31:0] acc_ff, nxt_acc;
  beat_t       dst_ff, nxt_dst;
  logic        awready_ff, nxt_awready;
  logic        wready_ff, nxt_wready;
  logic        aw_got_ff, nxt_aw_got;
  logic        w_got_ff, nxt_w_got;
  logic [3:0]  awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0]  wstrb_ff, nxt_wstrb;
  logic        bvalid_ff, nxt_bvalid;
  logic [1:0]  bresp_ff, nxt_bresp;
  logic        arready_ff, nxt_arready;
  logic        rvalid_ff, nxt_rvalid;
  logic [1:0]  rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;

  logic [1:0]  byte_order_select;
  logic        write_reorder_select;
  logic        bit_order_select;
  logic [4:0]  poly_length_field;
  logic        checksum_enable;
  logic        append_result_mode;
  logic        checksum_mode_select;
  logic [2:0]  routed_channel_select;
  logic [31:0] fed_word;
  logic [31:0] step_out;
  logic        routed;
  logic [31:0] wr_bits;
  logic [31:0] new_ctl;

  assign byte_order_select     = ctl_ff[byte_order_hi:byte_order_lo];   // see RQ3
  assign write_reorder_select  = ctl_ff[write_reorder_b];
  assign bit_order_select      = ctl_ff[bit_order_b];                   // see RQ9
  assign poly_length_field     = ctl_ff[poly_len_hi:poly_len_lo];
  assign checksum_enable       = ctl_ff[enable_b];
  assign append_result_mode    = ctl_ff[append_b];
  assign checksum_mode_select  = ctl_ff[mode_b];
  assign routed_channel_select = ctl_ff[chan_hi:chan_lo];

  byte_reorder u_reorder (
    .order (byte_order_select),
    .din   (src_beat.data),
    .dout  (fed_word)
  );

  // reflection applies equally in both modes
  crc_step u_step (
    .ip_mode     (checksum_mode_select),
    .reflect     (bit_order_select),                                    // see RQ7 see RQ8
    .poly_len_m1 (poly_length_field),
    .poly        (poly_ff),
    .acc         (acc_ff),
    .din         (fed_word),
    .acc_out     (step_out)
  );

  assign routed = checksum_enable && src_beat.valid
                  && (src_beat.chan == routed_channel_select);          // see RQ11 see RQ13

  // register write merge with byte strobes
  always_comb begin
    wr_bits = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      wr_bits[i*8 +: 8] = wstrb_ff[i] ? wdata_ff[i*8 +: 8] : ctl_ff[i*8 +: 8];
    end
    new_ctl = wr_bits & ctl_wmask;                                      // see RQ12
    if (new_ctl[write_reorder_b]) begin
      new_ctl[append_b] = 1'b0;                                         // see RQ5
    end
  end

  always_comb begin
    nxt_ctl     = ctl_ff;
    nxt_poly    = poly_ff;
    nxt_acc     = acc_ff;
    nxt_awready = awready_ff;
    nxt_wready  = wready_ff;
    nxt_aw_got  = aw_got_ff;
    nxt_w_got   = w_got_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_arready = arready_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rresp   = rresp_ff;
    nxt_rdata   = rdata_ff;
    nxt_dst     = src_beat;

    // destination data: reordered only on the routed channel
    if (routed && write_reorder_select) begin
      nxt_dst.data = fed_word;                                          // see RQ4
    end
    if (routed) begin
      nxt_acc = step_out;
    end

    // write channel: address and data accepted in either order
    if (awready_ff && s_awvalid) begin
      nxt_awready = 1'b0;
      nxt_aw_got  = 1'b1;
      nxt_awaddr  = s_awaddr;
    end
    if (wready_ff && s_wvalid) begin
      nxt_wready = 1'b0;
      nxt_w_got  = 1'b1;
      nxt_wdata  = s_wdata;
      nxt_wstrb  = s_wstrb;
    end
    if (aw_got_ff && w_got_ff && !bvalid_ff) begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = resp_okay;
      case (awaddr_ff)
        ctl_addr:    nxt_ctl  = new_ctl;
        poly_addr:   nxt_poly = wdata_ff;
        seed_addr:   nxt_acc  = wdata_ff;
        result_addr: nxt_bresp = resp_slverr;
        default:     nxt_bresp = resp_slverr;
      endcase
    end
    if (bvalid_ff && s_bready) begin
      nxt_bvalid  = 1'b0;
      nxt_awready = 1'b1;
      nxt_wready  = 1'b1;
    end

    // read channel
    if (arready_ff && s_arvalid) begin
      nxt_arready = 1'b0;
      nxt_rvalid  = 1'b1;
      nxt_rresp   = resp_okay;
      case (s_araddr)
        ctl_addr:    nxt_rdata = ctl_ff & ctl_wmask;                    // see RQ12
        poly_addr:   nxt_rdata = poly_ff;
        result_addr: nxt_rdata = acc_ff;
        seed_addr:   nxt_rdata = acc_ff;
        default: begin
          nxt_rdata = zero_word;
          nxt_rresp = resp_slverr;
        end
      endcase
    end
    if (rvalid_ff && s_rready) begin
      nxt_rvalid  = 1'b0;
      nxt_arready = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_ff     <= ctl_reset;                                          // see RQ14
      poly_ff    <= 32'h0000_0000;
      acc_ff     <= 32'h0000_0000;
      dst_ff     <= '0;
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      awaddr_ff  <= 4'h0;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'h0;
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= 2'h0;
      rdata_ff   <= 32'h0000_0000;
    end else begin
      ctl_ff     <= nxt_ctl;
      poly_ff    <= nxt_poly;
      acc_ff     <= nxt_acc;
      dst_ff     <= nxt_dst;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      aw_got_ff  <= nxt_aw_got;
      w_got_ff   <= nxt_w_got;
      awaddr_ff  <= nxt_awaddr;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rresp_ff   <= nxt_rresp;
      rdata_ff   <= nxt_rdata;
    end
  end

  logic append_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      append_ff <= 1'b0;
    end else begin
      append_ff <= append_result_mode && checksum_enable;
    end
  end

  assign s_awready  = awready_ff;
  assign s_wready   = wready_ff;
  assign s_bvalid   = bvalid_ff;
  assign s_bresp    = bresp_ff;
  assign s_arready  = arready_ff;
  assign s_rvalid   = rvalid_ff;
  assign s_rresp    = rresp_ff;
  assign s_rdata    = rdata_ff;
  assign dst_beat   = dst_ff;
  assign append_req = append_ff;

  property p_unimpl_zero;
    @(posedge clk) disable iff (!arst_n)
      (ctl_ff & ~ctl_wmask) == zero_word;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set"); // see RQ12

  property p_no_append_with_reorder;
    @(posedge clk) disable iff (!arst_n)
      ctl_ff[write_reorder_b] |-> !ctl_ff[append_b];
  endproperty
  a_no_append_with_reorder: assert property (p_no_append_with_reorder) else $error("append with reorder"); // see RQ5

  property p_passthru_unrouted;
    @(posedge clk) disable iff (!arst_n)
      !routed |=> dst_beat.data == $past(src_beat.data);
  endproperty
  a_passthru_unrouted: assert property (p_passthru_unrouted) else $error("unrouted data changed"); // see RQ11

  property p_passthru_no_reorder;
    @(posedge clk) disable iff (!arst_n)
      (routed && !write_reorder_select) |=> dst_beat.data == $past(src_beat.data);
  endproperty
  a_passthru_no_reorder: assert property (p_passthru_no_reorder) else $error("data altered"); // see RQ4

  property p_word_swap;
    @(posedge clk) disable iff (!arst_n)
      (routed && write_reorder_select && byte_order_select == order_word)
      |=> dst_beat.data[7:0] == $past(src_beat.data[31:24]);
  endproperty
  a_word_swap: assert property (p_word_swap) else $error("word reverse wrong"); // see RQ1

  property p_half_swap;
    @(posedge clk) disable iff (!arst_n)
      (routed && write_reorder_select && byte_order_select == order_half)
      |=> dst_beat.data[15:0] == $past(src_beat.data[31:16]);
  endproperty
  a_half_swap: assert property (p_half_swap) else $error("half swap wrong"); // see RQ2

  property p_acc_hold;
    @(posedge clk) disable iff (!arst_n)
      (!checksum_enable && !(aw_got_ff && w_got_ff)) |=> $stable(acc_ff);
  endproperty
  a_acc_hold: assert property (p_acc_hold) else $error("acc moved while off"); // see RQ11

  property p_ip_narrow;
    @(posedge clk) disable iff (!arst_n)
      (routed && checksum_mode_select && !(aw_got_ff && w_got_ff))
      |=> acc_ff[31:16] == 16'h0000;
  endproperty
  a_ip_narrow: assert property (p_ip_narrow) else $error("ip sum too wide"); // see RQ6

  property p_bresp_after_both;
    @(posedge clk) disable iff (!arst_n)
      $rose(bvalid_ff) |-> $past(aw_got_ff) && $past(w_got_ff);
  endproperty
  a_bresp_after_both: assert property (p_bresp_after_both) else $error("early write response"); // write response raised only after both address and data are captured
endmodule
`default_nettype wire

//--- tb/dma_source.sv
`timescale 1ns/100ps
`default_nettype none
module dma_source
  import crc_ctl_pkg::*;
(
  // clock
  input  wire logic          clk,
  // request from the bench
  input  wire logic          send,
  input  wire logic [2:0]    chan,
  input  wire logic [31:0]   data,
  // beat into the unit
  output crc_ctl_pkg::beat_t src_beat
);
  logic [31:0] junk_ff = 32'h5a5a_0f0f;
  logic [31:0] nxt_junk;
  // idle data is inverted and xored with data every cycle so a stale word never looks like a beat
  always_comb begin
    nxt_junk = ~junk_ff ^ data;
    src_beat = send ? {1'b1, chan, data} : {1'b0, chan, junk_ff};
  end
  always_ff @(posedge clk) begin
    junk_ff <= nxt_junk;
  end
endmodule
`default_nettype wire

//--- tb/test_dma_crc_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_dma_crc_control;
  import crc_ctl_pkg::*;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [3:0]  s_awaddr = 4'h0;
  logic [3:0]  s_araddr = 4'h0;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0]  s_wstrb = 4'hf;
  logic        s_awvalid = 1'b0;
  logic        s_wvalid = 1'b0;
  logic        s_bready = 1'b0;
  logic        s_arvalid = 1'b0;
  logic        s_rready = 1'b0;
  logic        send = 1'b0;
  logic [2:0]  b_chan = 3'h0;
  logic [31:0] b_data = 32'h0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, append_req;
  logic [1:0]  s_bresp, s_rresp;
  logic [31:0] s_rdata, ctl, poly, acc;
  beat_t       src, dst;
  int          bad_count = 0;
  int          num_checks = 0;
  int          cycles = 0;

  always #20 clk = ~clk;

  dma_source i_src (.clk(clk), .send(send), .chan(b_chan), .data(b_data), .src_beat(src));

  dma_crc_control #(.channels(8)) i_dut (
    .clk(clk), .arst_n(arst_n),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .src_beat(src), .dst_beat(dst), .append_req(append_req)
  );

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge clk);
      ta = ta | s_awready;
      tw = tw | s_wready;
      @(posedge clk);
      if (ta) s_awvalid <= 1'b0;
      if (tw) s_wvalid <= 1'b0;
    end
    @(negedge clk);
    while (s_bvalid !== 1'b1) @(negedge clk);
    chk({30'h0, s_bresp}, {30'h0, er});
    @(posedge clk);
    s_bready <= 1'b0;
    // one idle edge so a following call never re-drives bready in this step
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] q, input logic [1:0] er);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    @(negedge clk);
    while (s_arready !== 1'b1) @(negedge clk);
    @(posedge clk);
    s_arvalid <= 1'b0;
    @(negedge clk);
    while (s_rvalid !== 1'b1) @(negedge clk);
    q = s_rdata;
    chk({30'h0, s_rresp}, {30'h0, er});
    @(posedge clk);
    s_rready <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] reord(input logic [1:0] o, input logic [31:0] d);
    case (o)
      2'h1: return {d[7:0], d[15:8], d[23:16], d[31:24]};
      2'h2: return {d[15:0], d[31:16]};
      2'h3: return {d[23:16], d[31:24], d[7:0], d[15:8]};
      default: return d;
    endcase
  endfunction

  function automatic logic [31:0] lmask();
    int w;
    w = ctl[poly_len_hi:poly_len_lo] + 1;
    return (w == 32) ? 32'hffff_ffff : (32'h1 << w) - 32'h1;
  endfunction

  function automatic logic [31:0] step(input logic [31:0] a, input logic [31:0] d);
    logic [32:0] s;
    int          w;
    logic        fb;
    w = ctl[poly_len_hi:poly_len_lo] + 1;
    if (ctl[bit_order_b]) d = {<<{d}};
    if (ctl[mode_b]) begin
      s = a[15:0] + d[31:16] + d[15:0];
      s = s[15:0] + s[32:16];
      s = s[15:0] + s[32:16];
      return {16'h0, s[15:0]};
    end
    for (int i = 31; i >= 0; i--) begin
      fb = a[w-1] ^ d[i];
      a = ((a << 1) ^ (fb ? poly : 32'h0)) & lmask();
    end
    return a;
  endfunction

  task automatic beat(input logic [2:0] c, input logic [31:0] d);
    logic        hit;
    logic [31:0] e;
    hit = ctl[enable_b] && c == ctl[chan_hi:chan_lo];
    e = (hit && ctl[write_reorder_b]) ? reord(ctl[byte_order_hi:byte_order_lo], d) : d;
    if (hit) acc = step(acc, reord(ctl[byte_order_hi:byte_order_lo], d));
    send <= 1'b1;
    b_chan <= c;
    b_data <= d;
    @(posedge clk);
    send <= 1'b0;
    @(negedge clk);
    chk({28'h0, dst.valid, dst.chan}, {28'h0, 1'b1, c});
    chk(dst.data, e);
    @(posedge clk);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    logic [31:0] q;
    logic [31:0] c;
    q = $urandom(39501);
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(ctl_addr, q, resp_okay);
    chk(q, ctl_reset);
    chk({31'h0, append_req}, zero_word);
    wr(ctl_addr, 32'hffff_ffff, resp_okay);
    rd(ctl_addr, q, resp_okay);
    chk(q, ctl_wmask & ~(32'h1 << append_b));
    wr(result_addr, 32'h1234_5678, resp_slverr);
    rd(4'h2, q, resp_slverr);
    chk(q, zero_word);
    for (int n = 0; n < 24; n++) begin
      c = $urandom() & ctl_wmask;
      if (n < 16) begin
        c[byte_order_hi:byte_order_lo] = n[1:0];
        c[mode_b] = n[2];
        c[write_reorder_b] = n[3];
        c[enable_b] = 1'b1;
      end
      // software never asks for append while reordering writes
      if (c[write_reorder_b]) c[append_b] = 1'b0;
      ctl = c;
      poly = $urandom();
      acc = $urandom();
      wr(ctl_addr, c, resp_okay);
      wr(poly_addr, poly, resp_okay);
      wr(seed_addr, acc, resp_okay);
      rd(ctl_addr, q, resp_okay);
      chk(q, c);
      chk({31'h0, append_req}, {31'h0, c[enable_b] & c[append_b]});
      beat(c[chan_hi:chan_lo], $urandom());
      repeat (3) beat(3'($urandom()), $urandom());
      rd(result_addr, q, resp_okay);
      chk(q, acc);
    end
    // second reset in mid-run: the control word must come back cleared
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(ctl_addr, q, resp_okay);
    chk(q, ctl_reset);
    chk({31'h0, append_req}, zero_word);
    rd(seed_addr, q, resp_okay);
    chk(q, zero_word);
    // only the low byte lane is written; the rest keeps its reset value
    s_wstrb <= 4'h1;
    wr(ctl_addr, 32'hffff_ffff, resp_okay);
    s_wstrb <= 4'hf;
    rd(ctl_addr, q, resp_okay);
    chk(q, ctl_wmask & 32'h0000_00ff);
    summarize();
  end
endmodule
`default_nettype wire
